// ==== video_encoder_config_regs.svh ====
// Register indexes, field positions, reset values and bit counts of the encoder configuration bank
`ifndef VIDEO_ENCODER_CONFIG_REGS_SVH
`define VIDEO_ENCODER_CONFIG_REGS_SVH

// Register indexes as reached through the register pointer
`define IDX_OUT_STD_FILT   2'h0
`define IDX_DAC_PWR_OVS    2'h1
`define IDX_ROUTE_SLEEP    2'h2
`define IDX_REV_VBI        2'h3
`define PTR_LAST           8'h03
`define PTR_STEP           8'h01
`define PTR_RESET          8'h00

// Register 0 fields
`define STD_MSB            1
`define STD_LSB            0
`define LUMA_MSB           4
`define LUMA_LSB           2
`define CHROMA_MSB         7
`define CHROMA_LSB         5

// Register 1 fields
`define DACPD_MSB          5
`define DACPD_LSB          0
`define OVS_BIT            6

// Register 2 fields
`define RGBYUV_BIT         0
`define FIRST3_BIT         1
`define SCART_BIT          2
`define PED_BIT            3
`define SQPIX_BIT          4
`define STDSRC_BIT         5
`define PXVALID_BIT        6
`define SLEEP_BIT          7

// Register 3 fields
`define REV_MSB            1
`define REV_LSB            0
`define VBI_MSB            7
`define VBI_LSB            2

// Reset values and write masks
`define OUT_STD_FILT_RST   8'h00
`define DAC_PWR_OVS_RST    8'h00
`define ROUTE_SLEEP_RST    8'h00
`define REV_VBI_RST        8'h00
`define WMASK_FULL         8'hff
`define WMASK_REV_VBI      8'hfc

// Serial byte framing
`define BIT_FIRST          4'h0
`define BIT_LAST_DATA      4'h7
`define BIT_ACK            4'h8
`define BIT_STEP           4'h1
`define ADDR_SEL_BIT       1
`define RW_BIT             0

`endif

// ==== video_encoder_config_pkg.sv ====
// Types shared by the encoder configuration bank modules
package video_encoder_config_pkg;

  // Output video standards
  typedef enum logic [1:0] {
    STD_NTSC      = 2'h0,
    STD_PAL_BDGHI = 2'h1,
    STD_PAL_M     = 2'h2,
    STD_PAL_N     = 2'h3
  } video_std_t;

  // Signal carried by one DAC
  typedef enum logic [3:0] {
    SRC_G      = 4'h0,
    SRC_B      = 4'h1,
    SRC_R      = 4'h2,
    SRC_Y      = 4'h3,
    SRC_U      = 4'h4,
    SRC_V      = 4'h5,
    SRC_CVBS   = 4'h6,
    SRC_LUMA   = 4'h7,
    SRC_CHROMA = 4'h8
  } dac_src_t;

  // Serial link states
  typedef enum logic [4:0] {
    LK_IDLE  = 5'h01,
    LK_ADDR  = 5'h02,
    LK_PTR   = 5'h04,
    LK_WDATA = 5'h08,
    LK_RDATA = 5'h10
  } link_state_t;

endpackage

// ==== pin_sync.sv ====
// Three-stage synchroniser with agreement filter for inputs from other domains
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  // Foreign levels and their filtered copy
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // Plain pipeline; only the second stage reads the first
  always_ff @(posedge i_clk) begin
    s1_r <= i_async;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // A change counts once the last two stages agree
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        o_level[g] <= s3_r[g];
      end else if (s2_r[g] == s3_r[g]) begin
        o_level[g] <= s3_r[g];
      end
    end
  end

endmodule
`default_nettype wire

// ==== dac_route.sv ====
// Decoder from the three routing selects to the signal on each of six DACs
`timescale 1ns/1ps
`default_nettype none
module dac_route (
  // Routing selects
  input  wire logic                               i_scart,
  input  wire logic                               i_first3_composite,
  input  wire logic                               i_yuv,
  // Signal carried by each DAC
  output video_encoder_config_pkg::dac_src_t      o_dac_a,
  output video_encoder_config_pkg::dac_src_t      o_dac_b,
  output video_encoder_config_pkg::dac_src_t      o_dac_c,
  output video_encoder_config_pkg::dac_src_t      o_dac_d,
  output video_encoder_config_pkg::dac_src_t      o_dac_e,
  output video_encoder_config_pkg::dac_src_t      o_dac_f
);
  import video_encoder_config_pkg::*;

  dac_src_t c1;
  dac_src_t c2;
  dac_src_t c3;

  // Component triple follows the colour-space select
  always_comb begin
    c1 = i_yuv ? SRC_Y : SRC_G;
    c2 = i_yuv ? SRC_U : SRC_B;
    c3 = i_yuv ? SRC_V : SRC_R;
  end

  // Eight combinations, composite-on-first-three wins over the scart split
  always_comb begin
    if (i_first3_composite) begin
      o_dac_a = SRC_CVBS;
      o_dac_b = SRC_LUMA;
      o_dac_c = SRC_CHROMA;
      o_dac_d = c1;
      o_dac_e = c2;
      o_dac_f = c3;
    end else if (i_scart) begin
      o_dac_a = SRC_CVBS;
      o_dac_b = c2;
      o_dac_c = c3;
      o_dac_d = c1;
      o_dac_e = SRC_LUMA;
      o_dac_f = SRC_CHROMA;
    end else begin
      o_dac_a = c1;
      o_dac_b = c2;
      o_dac_c = c3;
      o_dac_d = SRC_CVBS;
      o_dac_e = SRC_LUMA;
      o_dac_f = SRC_CHROMA;
    end
  end

endmodule
`default_nettype wire

// ==== video_encoder_config_regs.sv ====
// Two-wire serial slave and mode register bank that configures the video encoder
//
// Behaviour
// - Byte after device address loads pointer; pin sets address bit
// - Pointer advances after every data byte
// - Start anywhere restarts; stray stops are not detected
// - Unimplemented pointer gets no acknowledge, idle
// - Reads past top repeat top register
// - Writes past top discarded, not acknowledged, idle
// - Pointer write-only, set each transfer; others read/write
// - Two-bit field selects output standard
// - Three-bit luma filter select, any standard
// - Three-bit chroma filter select
// - Six DAC power-down bits; reserved top bit
// - Oversampling bit selects 54 MHz output
// - Three selects fix every DAC's signal
// - Pedestal only on NTSC, ignored for PAL
// - Square pixel only slave timing, no oversampling
// - Source bit picks register or pin standard
// - Pixel valid resets zero; zero blanks, forces master
// - Sleep bit sleeps when enabled, reset exits
// - Revision bits read-only, writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "video_encoder_config_regs.svh"
module video_encoder_config_regs #(
  parameter logic [6:0] SLAVE_ADDR_BASE = 7'h2a, // Arbitrary base address
  parameter logic [1:0] REVISION        = 2'h1   // Arbitrary revision code
) (
  // Core clock and reset
  input  wire logic                                 i_clk,
  input  wire logic                                 i_nrst,
  // Serial link
  input  wire logic                                 i_scl,
  input  wire logic                                 i_sda,
  output logic                                      o_sda_out,
  output logic                                      o_sda_oe,
  // Pins and neighbouring control
  input  wire logic                                 i_address_select_pin,
  input  wire logic                                 i_standard_select_pin,
  input  wire logic                                 i_pin_sleep_request,
  input  wire logic                                 i_power_up_sleep_control,
  input  wire logic                                 i_pll_enable_control,
  input  wire logic                                 i_timing_slave,
  // Standard and filters
  output video_encoder_config_pkg::video_std_t      o_video_standard,
  output logic [2:0]                                o_luma_filter,
  output logic [2:0]                                o_chroma_filter,
  // DAC control
  output logic [5:0]                                o_dac_power_down,
  output logic                                      o_oversample,
  output logic                                      o_pll_conflict,
  output video_encoder_config_pkg::dac_src_t        o_dac_a_src,
  output video_encoder_config_pkg::dac_src_t        o_dac_b_src,
  output video_encoder_config_pkg::dac_src_t        o_dac_c_src,
  output video_encoder_config_pkg::dac_src_t        o_dac_d_src,
  output video_encoder_config_pkg::dac_src_t        o_dac_e_src,
  output video_encoder_config_pkg::dac_src_t        o_dac_f_src,
  // Picture and power
  output logic                                      o_pedestal_on,
  output logic                                      o_square_pixel,
  output logic                                      o_pixel_blank,
  output logic                                      o_force_master_timing,
  output logic                                      o_sleep,
  output logic [5:0]                                o_vbi_teletext_ctrl
);
  import video_encoder_config_pkg::*;

  // Core-domain storage and crossings
  logic [7:0]  cfg_r [4];
  logic [3:0]  pin_lvl;
  logic        wr_seen_r;
  logic        wr_event;
  logic [6:0]  slave_addr;
  video_std_t  eff_std;
  dac_src_t    route [6];
  // Link-domain state
  link_state_t lk_state_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  rx_r;
  logic [7:0]  tx_r;
  logic [7:0]  ptr_r;
  logic [7:0]  ptr_nxt;
  logic        sda_hi_r;
  logic        start_det;
  logic        byte_ok;
  logic        wr_tgl_r;
  logic [1:0]  wr_addr_r;
  logic [7:0]  wr_data_r;
  logic        lrst_s1_r;
  logic        lrst_s2_r;
  logic        lrst_s3_r;
  logic        lk_nrst_r;

  // Readback of one register; pointers beyond the top see the top register
  function automatic logic [7:0] reg_read(input logic [7:0] idx);
    logic [1:0] i;
    i = (idx > `PTR_LAST) ? `IDX_REV_VBI : idx[1:0];
    if (i == `IDX_REV_VBI) begin
      reg_read = {cfg_r[i][`VBI_MSB:`VBI_LSB], REVISION};
    end else begin
      reg_read = cfg_r[i];
    end
  endfunction

  // Leading bit of a register, driven first on a read; a call result cannot be bit-selected
  function automatic logic read_msb(input logic [7:0] idx);
    logic [7:0] v;
    v = reg_read(idx);
    read_msb = v[7];
  endfunction

  // Bits that software may change in each register
  function automatic logic [7:0] wr_mask(input logic [1:0] idx);
    wr_mask = (idx == `IDX_REV_VBI) ? `WMASK_REV_VBI : `WMASK_FULL;
  endfunction

  // Strap, standard pin, sleep pin and write toggle all come from other domains
  pin_sync #(
    .WIDTH (4)
  ) u_pins (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_async ({wr_tgl_r, i_pin_sleep_request, i_standard_select_pin, i_address_select_pin}),
    .o_level (pin_lvl)
  );

  // A filtered toggle change is one completed write byte
  always_ff @(posedge i_clk) begin
    wr_seen_r <= pin_lvl[3];
  end
  assign wr_event = (pin_lvl[3] != wr_seen_r) && i_nrst;

  // Address-select pin replaces one bit of the slave address
  always_comb begin
    slave_addr                = SLAVE_ADDR_BASE;
    slave_addr[`ADDR_SEL_BIT] = pin_lvl[0];
  end

  // Mode registers; write data and address are stable long before the toggle lands
  for (genvar g = 0; g < 4; g++) begin : g_reg
    always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
        cfg_r[g] <= (g == 0) ? `OUT_STD_FILT_RST : (g == 1) ? `DAC_PWR_OVS_RST :
                    (g == 2) ? `ROUTE_SLEEP_RST : `REV_VBI_RST;
      end else if (wr_event && (wr_addr_r == 2'(g))) begin
        cfg_r[g] <= wr_data_r & wr_mask(2'(g));
      end
    end
  end

  // Effective standard: programmed or pin-selected
  always_comb begin
    if (cfg_r[`IDX_ROUTE_SLEEP][`STDSRC_BIT]) begin
      eff_std = video_std_t'(cfg_r[`IDX_OUT_STD_FILT][`STD_MSB:`STD_LSB]);
    end else begin
      eff_std = pin_lvl[1] ? STD_PAL_BDGHI : STD_NTSC;
    end
  end

  dac_route u_route (
    .i_scart            (cfg_r[`IDX_ROUTE_SLEEP][`SCART_BIT]),
    .i_first3_composite (cfg_r[`IDX_ROUTE_SLEEP][`FIRST3_BIT]),
    .i_yuv              (cfg_r[`IDX_ROUTE_SLEEP][`RGBYUV_BIT]),
    .o_dac_a            (route[0]),
    .o_dac_b            (route[1]),
    .o_dac_c            (route[2]),
    .o_dac_d            (route[3]),
    .o_dac_e            (route[4]),
    .o_dac_f            (route[5])
  );

  // Settings to the datapath, one register stage behind the bank
  always_ff @(posedge i_clk) begin
    o_video_standard      <= eff_std;
    o_luma_filter         <= cfg_r[`IDX_OUT_STD_FILT][`LUMA_MSB:`LUMA_LSB];
    o_chroma_filter       <= cfg_r[`IDX_OUT_STD_FILT][`CHROMA_MSB:`CHROMA_LSB];
    o_dac_power_down      <= cfg_r[`IDX_DAC_PWR_OVS][`DACPD_MSB:`DACPD_LSB];
    o_oversample          <= cfg_r[`IDX_DAC_PWR_OVS][`OVS_BIT];
    o_pll_conflict        <= cfg_r[`IDX_DAC_PWR_OVS][`OVS_BIT] & i_pll_enable_control;
    o_dac_a_src           <= route[0];
    o_dac_b_src           <= route[1];
    o_dac_c_src           <= route[2];
    o_dac_d_src           <= route[3];
    o_dac_e_src           <= route[4];
    o_dac_f_src           <= route[5];
    o_pedestal_on         <= cfg_r[`IDX_ROUTE_SLEEP][`PED_BIT] & (eff_std == STD_NTSC);
    // Square pixel needs slave timing, which invalid pixels would override
    o_square_pixel        <= cfg_r[`IDX_ROUTE_SLEEP][`SQPIX_BIT] & ~cfg_r[`IDX_DAC_PWR_OVS][`OVS_BIT] &
                             i_timing_slave & cfg_r[`IDX_ROUTE_SLEEP][`PXVALID_BIT];
    o_pixel_blank         <= ~cfg_r[`IDX_ROUTE_SLEEP][`PXVALID_BIT];
    o_force_master_timing <= ~cfg_r[`IDX_ROUTE_SLEEP][`PXVALID_BIT];
    o_sleep               <= i_power_up_sleep_control ? pin_lvl[2] :
                             cfg_r[`IDX_ROUTE_SLEEP][`SLEEP_BIT];
    o_vbi_teletext_ctrl   <= cfg_r[`IDX_REV_VBI][`VBI_MSB:`VBI_LSB];
  end

  // Reset reaches the link side through three stages on the falling link edge
  always_ff @(negedge i_scl) begin
    lrst_s1_r <= i_nrst;
    lrst_s2_r <= lrst_s1_r;
    lrst_s3_r <= lrst_s2_r;
    if (lrst_s2_r == lrst_s3_r) begin
      lk_nrst_r <= lrst_s3_r;
    end
  end

  // Data is sampled while the link clock is high; acknowledge slot never shifts
  always_ff @(posedge i_scl) begin
    sda_hi_r <= i_sda;
    if (bit_cnt_r != `BIT_ACK) begin
      rx_r <= {rx_r[6:0], i_sda};
    end
  end

  // Falling edge after a high with data falling: a start, wherever it happens
  assign start_det = sda_hi_r & ~i_sda;

  // Acceptance of the byte just received
  always_comb begin
    case (lk_state_r)
      LK_ADDR:  byte_ok = (rx_r[7:1] == slave_addr);
      LK_PTR:   byte_ok = (rx_r <= `PTR_LAST);
      LK_WDATA: byte_ok = (ptr_r <= `PTR_LAST);
      default:  byte_ok = 1'b0;
    endcase
  end

  // Next read pointer stays on the top register once there
  assign ptr_nxt = (ptr_r < `PTR_LAST) ? ptr_r + `PTR_STEP : ptr_r;

  // Link state machine; bus outputs change only on the falling link edge
  always_ff @(negedge i_scl) begin
    if (!lk_nrst_r) begin
      lk_state_r <= LK_IDLE;
      bit_cnt_r  <= `BIT_FIRST;
      o_sda_oe   <= 1'b0;
      o_sda_out  <= 1'b0;
      ptr_r      <= `PTR_RESET;
      tx_r       <= `REV_VBI_RST;
      wr_tgl_r   <= 1'b0;
      wr_addr_r  <= `IDX_OUT_STD_FILT;
      wr_data_r  <= `OUT_STD_FILT_RST;
    end else if (start_det) begin
      lk_state_r <= LK_ADDR;
      bit_cnt_r  <= `BIT_FIRST;
      o_sda_oe   <= 1'b0;
    end else begin
      case (lk_state_r)
        LK_ADDR, LK_PTR, LK_WDATA: begin
          if (bit_cnt_r == `BIT_LAST_DATA) begin
            bit_cnt_r <= `BIT_ACK;
            o_sda_oe  <= byte_ok;
            if (!byte_ok) begin
              lk_state_r <= LK_IDLE;
            end
          end else if (bit_cnt_r == `BIT_ACK) begin
            bit_cnt_r <= `BIT_FIRST;
            o_sda_oe  <= 1'b0;
            if (lk_state_r == LK_ADDR && rx_r[`RW_BIT]) begin
              lk_state_r <= LK_RDATA;
              tx_r       <= reg_read(ptr_r);
              o_sda_oe   <= ~read_msb(ptr_r);
            end else if (lk_state_r == LK_ADDR) begin
              lk_state_r <= LK_PTR;
            end else if (lk_state_r == LK_PTR) begin
              ptr_r      <= rx_r;
              lk_state_r <= LK_WDATA;
            end else begin
              // Hand the byte over after its acknowledge has finished
              wr_addr_r <= ptr_r[1:0];
              wr_data_r <= rx_r;
              wr_tgl_r  <= ~wr_tgl_r;
              ptr_r     <= ptr_r + `PTR_STEP;
            end
          end else begin
            bit_cnt_r <= bit_cnt_r + `BIT_STEP;
          end
        end
        LK_RDATA: begin
          if (bit_cnt_r == `BIT_LAST_DATA) begin
            bit_cnt_r <= `BIT_ACK;
            o_sda_oe  <= 1'b0;
          end else if (bit_cnt_r == `BIT_ACK) begin
            bit_cnt_r <= `BIT_FIRST;
            if (!sda_hi_r) begin
              ptr_r    <= ptr_nxt;
              tx_r     <= reg_read(ptr_nxt);
              o_sda_oe <= ~read_msb(ptr_nxt);
            end else begin
              lk_state_r <= LK_IDLE;
            end
          end else begin
            bit_cnt_r <= bit_cnt_r + `BIT_STEP;
            tx_r      <= {tx_r[6:0], 1'b0};
            o_sda_oe  <= ~tx_r[6];
          end
        end
        LK_IDLE: begin
          o_sda_oe <= 1'b0;
        end
        default: begin
          lk_state_r <= LK_IDLE;
          o_sda_oe   <= 1'b0;
        end
      endcase
    end
  end

  // Checks on the link side
  sequence byte_done_s(link_state_t st);
    lk_state_r == st && bit_cnt_r == `BIT_LAST_DATA && !start_det;
  endsequence

  AST_BAD_PTR_NACK: assert property (@(negedge i_scl) disable iff (!lk_nrst_r)
    byte_done_s(LK_PTR) ##0 (rx_r > `PTR_LAST) |=> lk_state_r == LK_IDLE && !o_sda_oe)
    else $error("unimplemented pointer was acknowledged");

  AST_WRITE_OVERRUN: assert property (@(negedge i_scl) disable iff (!lk_nrst_r)
    byte_done_s(LK_WDATA) ##0 (ptr_r > `PTR_LAST) |=> lk_state_r == LK_IDLE && !o_sda_oe)
    else $error("write past top register was acknowledged");

  AST_WRITE_AUTOINC: assert property (@(negedge i_scl) disable iff (!lk_nrst_r)
    lk_state_r == LK_WDATA && bit_cnt_r == `BIT_ACK && !start_det |=>
      ptr_r == $past(ptr_r) + `PTR_STEP && wr_tgl_r != $past(wr_tgl_r))
    else $error("write pointer did not advance");

  AST_READ_SATURATE: assert property (@(negedge i_scl) disable iff (!lk_nrst_r)
    lk_state_r == LK_RDATA && bit_cnt_r == `BIT_ACK && !sda_hi_r && !start_det && ptr_r >= `PTR_LAST
      |=> ptr_r == $past(ptr_r) && lk_state_r == LK_RDATA)
    else $error("read pointer moved past top register");

  AST_START_RESTART: assert property (@(negedge i_scl) disable iff (!lk_nrst_r)
    start_det |=> lk_state_r == LK_ADDR && bit_cnt_r == `BIT_FIRST && !o_sda_oe)
    else $error("start did not restart the link");

  // Checks on the core side
  AST_WRITE_APPLY: assert property (@(posedge i_clk) disable iff (!i_nrst)
    wr_event |=> (reg_read({6'h00, $past(wr_addr_r)}) & wr_mask($past(wr_addr_r))) ==
                 ($past(wr_data_r) & wr_mask($past(wr_addr_r))) &&
                 cfg_r[`IDX_REV_VBI][`REV_MSB:`REV_LSB] == 2'h0)
    else $error("written value not read back");

  AST_PIXEL_BLANK: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !cfg_r[`IDX_ROUTE_SLEEP][`PXVALID_BIT] ##1 !cfg_r[`IDX_ROUTE_SLEEP][`PXVALID_BIT]
      |-> o_pixel_blank && o_force_master_timing && !o_square_pixel)
    else $error("pixels not blanked while invalid");

  AST_STD_SOURCE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    cfg_r[`IDX_ROUTE_SLEEP][`STDSRC_BIT] |=>
      o_video_standard == video_std_t'($past(cfg_r[`IDX_OUT_STD_FILT][`STD_MSB:`STD_LSB])))
    else $error("programmed standard not applied");

  AST_PEDESTAL_NTSC: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_pedestal_on |-> o_video_standard == STD_NTSC)
    else $error("pedestal on a PAL standard");

  AST_SQUARE_NO_OVS: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_square_pixel |-> !o_oversample && $past(i_timing_slave))
    else $error("square pixel with oversampling or master timing");

  AST_SLEEP_SOURCE: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_power_up_sleep_control |=> o_sleep == $past(cfg_r[`IDX_ROUTE_SLEEP][`SLEEP_BIT]))
    else $error("sleep does not follow register bit");

endmodule
`default_nettype wire

// ==== video_encoder_config_regs_notes_unused.sv ====
// Intentionally empty compilation unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== serial_master_model.sv ====
// Two-wire bus master model that drives the link clock and data
`timescale 1ns/1ps
`default_nettype none
module serial_master_model (
  // Wire levels
  output logic      o_scl,
  output logic      o_sda,
  input  wire logic i_sda
);
  // Lines released and clock standing high outside frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // One bit: data moves only while the clock is low
  task automatic slot(input logic d, output logic q);
    o_sda = d;
    #40 o_scl = 1'b1;
    #40 q = i_sda;
    #40 o_scl = 1'b0;
    #40;
  endtask
  // Start or repeated start, a single condition per clock high
  task automatic start();
    o_sda = 1'b1;
    // After a stop the clock stands high; take it low first so a start is seen
    if (o_scl) begin
      #40 o_scl = 1'b0;
      #40;
    end
    #40 o_scl = 1'b1;
    #40 o_sda = 1'b0;
    #40 o_scl = 1'b0;
    #40;
  endtask
  // Stop leaves both lines released
  task automatic stop();
    o_sda = 1'b0;
    #40 o_scl = 1'b1;
    #40 o_sda = 1'b1;
    #40;
  endtask
  // Byte out, MSB first, then release for the acknowledge
  task automatic wr(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) slot(b[i], q);
    slot(1'b1, q);
    ack = !q;
  endtask
  // Byte in; a last byte is answered with no acknowledge
  task automatic rd(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, q);
      b[i] = q;
    end
    slot(last, q);
  endtask
endmodule
`default_nettype wire

// ==== video_encoder_config_regs_bench.sv ====
// Self-checking bench for the encoder configuration bank
`timescale 1ns/1ps
`default_nettype none
module video_encoder_config_regs_bench;
  import video_encoder_config_pkg::*;
  logic       i_clk, i_nrst, scl, msda, oe, so, asel, stdpin, pll, ovs, conf, ped, sqp, blank, fmt, sleep, psc, ack;
  logic [2:0] luma, chroma;
  logic [5:0] dpd, vbi;
  logic [7:0] rb;
  logic [7:0] wv [4] = '{8'hb6, 8'h2b, 8'h77, 8'hff};
  logic [7:0] rv [6] = '{8'hb6, 8'h2b, 8'h77, 8'hfd, 8'hfd, 8'hfd};
  logic [7:0] bp [2] = '{8'h04, 8'h80};
  video_std_t std;
  dac_src_t   da, db, dc, dd, de, df;
  int         fails = 0, check_count = 0, cycles = 0;
  // Pull-up wins unless the master or the device pulls low
  wire logic  sda = msda & !oe;

  serial_master_model m (.o_scl(scl), .o_sda(msda), .i_sda(sda));
  video_encoder_config_regs dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda), .o_sda_out(so), .o_sda_oe(oe),
    .i_address_select_pin(asel), .i_standard_select_pin(stdpin), .i_pin_sleep_request(1'b0),
    .i_power_up_sleep_control(psc), .i_pll_enable_control(pll), .i_timing_slave(1'b1),
    .o_video_standard(std), .o_luma_filter(luma), .o_chroma_filter(chroma), .o_dac_power_down(dpd),
    .o_oversample(ovs), .o_pll_conflict(conf), .o_dac_a_src(da), .o_dac_b_src(db), .o_dac_c_src(dc),
    .o_dac_d_src(dd), .o_dac_e_src(de), .o_dac_f_src(df), .o_pedestal_on(ped), .o_square_pixel(sqp),
    .o_pixel_blank(blank), .o_force_master_timing(fmt), .o_sleep(sleep), .o_vbi_teletext_ctrl(vbi));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // A hang ends the run as a mismatch
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Address with pin low is base with bit 1 cleared
  task automatic sel(input logic [7:0] p);
    m.start();
    m.wr(8'h50, ack);
    chk("addr ack", ack, 1);
    m.wr(p, ack);
  endtask
  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    sel(p);
    m.wr(d, ack);
    chk("write ack", ack, 1);
    m.stop();
    repeat (20) @(negedge i_clk);
  endtask

  initial begin
    {i_nrst, asel, stdpin, pll, psc} = 5'h00;
    #7;
    // Link side must see reset over several clock falls
    repeat (8) m.slot(1'b1, ack);
    @(negedge i_clk) i_nrst = 1'b1;
    repeat (6) m.slot(1'b1, ack);
    chk("blank", blank, 1);
    chk("master timing", fmt, 1);
    chk("standard", std, STD_NTSC);
    chk("dac a", da, SRC_G);
    chk("dac d", dd, SRC_CVBS);
    m.start();
    m.wr(8'h54, ack);
    m.stop();
    chk("foreign ack", ack, 0);
    sel(8'h00);
    chk("ptr ack", ack, 1);
    foreach (wv[i]) begin
      m.wr(wv[i], ack);
      chk("data ack", ack, 1);
    end
    m.wr(8'h11, ack);
    chk("past top ack", ack, 0);
    m.stop();
    repeat (20) @(negedge i_clk);
    chk("standard", std, STD_PAL_M);
    chk("luma", luma, 3'h5);
    chk("chroma", chroma, 3'h5);
    chk("dac off", dpd, 6'h2b);
    chk("dac a", da, SRC_CVBS);
    chk("dac f", df, SRC_V);
    chk("square", sqp, 1);
    chk("blank", blank, 0);
    chk("vbi", vbi, 6'h3f);
    sel(8'h00);
    m.start();
    m.wr(8'h51, ack);
    foreach (rv[i]) begin
      m.rd(i == 5, rb);
      chk("read", rb, rv[i]);
    end
    m.stop();
    foreach (bp[i]) begin
      sel(bp[i]);
      m.stop();
      chk("bad ptr ack", ack, 0);
    end
    @(negedge i_clk) pll = 1'b1;
    wreg(8'h01, 8'h40);
    chk("oversample", ovs, 1);
    chk("pll conflict", conf, 1);
    chk("square", sqp, 0);
    wreg(8'h02, 8'hc8);
    chk("sleep", sleep, 1);
    chk("pedestal", ped, 1);
    @(negedge i_clk) psc = 1'b1;
    repeat (10) @(negedge i_clk);
    chk("pin sleep", sleep, 0);
    @(negedge i_clk) psc = 1'b0;
    @(negedge i_clk) stdpin = 1'b1;
    repeat (20) @(negedge i_clk);
    chk("standard", std, STD_PAL_BDGHI);
    chk("pedestal", ped, 0);
    // Stray stop inside a byte, then a normal write
    m.start();
    m.wr(8'h50, ack);
    m.slot(1'b0, ack);
    m.stop();
    wreg(8'h02, 8'h00);
    chk("sleep", sleep, 0);
    stop_test();
  end
endmodule
`default_nettype wire
